// ---- rtl/crl_loader.sv ----
// calibration register loader with wishbone register access
`timescale 1ns/1ps

module crl_loader #(
   parameter int unsigned REFRESH_CYC = crl_pkg::REFRESH_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [7:0] temp_code_i,
   input wire logic lock_override_i,
   output crl_pkg::crl_trim_s trims_o,
   output logic int_res_sel_o,
   output logic cal_mode_o
);
   crl_pkg::crl_st_e st_r;
   crl_pkg::crl_st_e st_nxt;
   logic [3:0] step_r;
   logic [7:0] lo_r;
   logic [7:0] lock_r;
   logic boot_r;
   logic cal_mode_r;
   logic pend_r;
   logic ack_r;
   logic [31:0] dat_r;
   logic [9:0] naddr_r;
   logic [15:0] cal_r [crl_pkg::NREGS];

   logic tick;
   logic [7:0] ptr;
   logic ovr_s;
   logic [7:0] nvm_rdata;
   logic [9:0] nvm_addr;
   logic nvm_we;
   logic nvm_erase;

   crl_tick #(
      .REFRESH_CYC(REFRESH_CYC)
   ) u_tick (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .temp_code_i(temp_code_i),
      .unlock_i(lock_override_i),
      .tick_o(tick),
      .ptr_o(ptr),
      .unlock_o(ovr_s)
   );

   crl_nvm u_nvm (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .addr_i(nvm_addr),
      .we_i(nvm_we),
      .wdata_i(wb_dat_i[7:0]),
      .erase_i(nvm_erase),
      .page_i(wb_dat_i[3:0]),
      .rdata_o(nvm_rdata)
   );

   // loader decode
   wire logic ld_req = boot_r | tick;
   wire logic ld_idle = st_r == crl_pkg::ST_IDLE;
   wire logic ld_start = ld_idle & ld_req;
   wire logic ld_busy = ~ld_idle | ld_req;
   wire logic ld_data = st_r == crl_pkg::ST_DATA;
   wire logic step0 = step_r == 4'h0;
   wire logic ld_last = step_r == crl_pkg::LAST_STEP;
   wire logic [3:0] stm1 = step_r - 4'h1;
   wire logic [2:0] ld_idx = stm1[3:1];
   // odd steps fetch the low byte, even steps from 2 the high byte; step 0 fetches the lock byte
   wire logic ld_hi = ~step_r[0];
   wire logic [9:0] ptr2 = {1'b0, ptr, 1'b0};
   wire logic [9:0] span_base;
   wire logic [9:0] word_addr;
   wire logic [9:0] ld_addr;

   assign span_base = (ptr < crl_pkg::SPAN_SPLIT) ? crl_pkg::SPAN_LO_BASE
                                                  : crl_pkg::SPAN_HI_BASE;
   assign word_addr = (ld_idx == 3'h0) ? crl_pkg::CFG_ADDR :
                      (ld_idx == 3'h1) ? crl_pkg::OTC_ADDR :
                      (ld_idx == 3'h2) ? crl_pkg::STC_ADDR :
                      (ld_idx == 3'h3) ? crl_pkg::OFS_BASE + ptr2 :
                      span_base + ptr2;
   assign ld_addr = step0 ? crl_pkg::LOCK_ADDR
                          : word_addr | {9'h000, ld_hi};

   wire logic cal_now = (nvm_rdata == crl_pkg::LOCK_OPEN) | ovr_s;
   wire logic cal_mode_w = (lock_r == crl_pkg::LOCK_OPEN) | ovr_s;
   wire logic ld_abort = ld_data & (step0 ? cal_now : cal_mode_w);
   wire logic ld_we = ld_data & ~ld_abort & ~step0 & ld_hi;

   always_comb begin
      st_nxt = st_r;
      case (st_r)
         crl_pkg::ST_IDLE: begin
            if (ld_req) begin
               st_nxt = crl_pkg::ST_ADDR;
            end
         end
         crl_pkg::ST_ADDR: begin
            st_nxt = crl_pkg::ST_DATA;
         end
         crl_pkg::ST_DATA: begin
            if (ld_abort || ld_last) begin
               st_nxt = crl_pkg::ST_IDLE;
            end else begin
               st_nxt = crl_pkg::ST_ADDR;
            end
         end
         default: begin
            st_nxt = crl_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r <= crl_pkg::ST_IDLE;
         step_r <= 4'h0;
         boot_r <= 1'b1;
      end else begin
         st_r <= st_nxt;
         if (ld_start) begin
            step_r <= 4'h0;
            boot_r <= 1'b0;
         end else if (ld_data) begin
            step_r <= step_r + 4'h1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lock_r <= crl_pkg::LOCK_RST;
         lo_r <= 8'h00;
      end else if (ld_data && step0) begin
         lock_r <= nvm_rdata;
      end else if (ld_data && !ld_hi) begin
         lo_r <= nvm_rdata;
      end
   end

   // bus decode
   wire logic bus_go = wb_cyc_i & wb_stb_i & ~ack_r;
   wire logic [5:0] wa = wb_adr_i[7:2];
   wire logic hit_stat = wa == crl_pkg::A_STATUS[7:2];
   wire logic hit_addr = wa == crl_pkg::A_NADDR[7:2];
   wire logic hit_data = wa == crl_pkg::A_NDATA[7:2];
   wire logic hit_erase = wa == crl_pkg::A_ERASE[7:2];
   wire logic hit_cal = (wb_adr_i >= crl_pkg::A_CAL0) &
                        (wb_adr_i < crl_pkg::A_CALEND);
   wire logic [7:0] cal_off = wb_adr_i - crl_pkg::A_CAL0;
   wire logic [2:0] cal_idx = cal_off[4:2];
   wire logic nvm_acc = hit_data | hit_erase;
   wire logic grant = bus_go & nvm_acc & ~pend_r & ~ld_busy;
   wire logic wr_ok = wb_we_i & cal_mode_w;
   wire logic [15:0] wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   wire logic cal_wr = bus_go & hit_cal & wr_ok;
   wire logic naddr_wr = bus_go & hit_addr & wb_we_i;
   wire logic ack_nxt = (bus_go & ~nvm_acc) | pend_r;
   wire logic [31:0] rd_w;

   assign nvm_addr = ld_idle ? naddr_r : ld_addr;
   assign nvm_we = grant & hit_data & wr_ok & wb_sel_i[0];
   assign nvm_erase = grant & hit_erase & wr_ok & wb_sel_i[0];

   assign rd_w = hit_stat ? {8'h00, lock_r, ptr, 5'h00, ~ld_idle,
                             ovr_s, cal_mode_r} :
                 hit_addr ? {22'h000000, naddr_r} :
                 hit_data ? {24'h000000, nvm_rdata} :
                 hit_cal ? {16'h0000, cal_r[cal_idx]} :
                 32'h00000000;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
         pend_r <= 1'b0;
         dat_r <= 32'h00000000;
         naddr_r <= 10'h000;
         cal_mode_r <= 1'b0;
      end else begin
         ack_r <= ack_nxt;
         pend_r <= grant;
         dat_r <= ack_nxt ? rd_w : 32'h00000000;
         cal_mode_r <= cal_mode_w;
         if (naddr_wr) begin
            naddr_r <= (naddr_r & ~wmask[9:0]) |
                       (wb_dat_i[9:0] & wmask[9:0]);
         end
      end
   end

   for (genvar g = 0; g < crl_pkg::NREGS; g++) begin : g_cal
      wire logic ld_hit = ld_we & (ld_idx == 3'(g));
      wire logic bus_hit = cal_wr & (cal_idx == 3'(g));
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            cal_r[g] <= crl_pkg::CAL_RST;
         end else if (ld_hit) begin
            cal_r[g] <= {nvm_rdata, lo_r};
         end else if (bus_hit) begin
            cal_r[g] <= (cal_r[g] & ~wmask) | (wb_dat_i[15:0] & wmask);
         end
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = dat_r;
   assign cal_mode_o = cal_mode_r;
   assign trims_o = '{span_trim: cal_r[4],
                      offset_trim: cal_r[3],
                      span_tc_trim: cal_r[2],
                      offset_tc_trim: cal_r[1],
                      config_word: cal_r[0]};
   assign int_res_sel_o = cal_r[0][crl_pkg::CFG_INTRES_BIT];

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_load_done;
      ##[1:30] (st_r == crl_pkg::ST_IDLE);
   endsequence

   property p_boot;
      $fell(rst_i) |-> s_load_done;
   endproperty
   a_boot: assert property (p_boot)
      else $error("boot load did not finish");

   property p_refresh;
      (tick && ld_idle) |=> (st_r == crl_pkg::ST_ADDR) ##0 s_load_done;
   endproperty
   a_refresh: assert property (p_refresh)
      else $error("refresh load did not run");

   property p_ofs_addr;
      (st_r == crl_pkg::ST_ADDR && step_r == 4'h7) |->
         nvm_addr == {1'b0, ptr, 1'b0};
   endproperty
   a_ofs_addr: assert property (p_ofs_addr)
      else $error("offset table address wrong");

   property p_span_addr;
      (st_r == crl_pkg::ST_ADDR && step_r == 4'h9 && ptr >= 8'h80) |->
         nvm_addr == 10'h1A0 + {1'b0, ptr - 8'h80, 1'b0};
   endproperty
   a_span_addr: assert property (p_span_addr)
      else $error("upper span table address wrong");

   property p_no_ld_cal;
      ld_we |-> !cal_mode_w;
   endproperty
   a_no_ld_cal: assert property (p_no_ld_cal)
      else $error("reload while in calibration mode");

   property p_calwr;
      (cal_wr && wb_sel_i == 4'hF) |=>
         cal_r[$past(cal_idx)] == $past(wb_dat_i[15:0]);
   endproperty
   a_calwr: assert property (p_calwr)
      else $error("bus write did not load register");

   property p_lock_wr;
      (bus_go && hit_cal && wb_we_i && !cal_mode_w && !ld_busy) |=>
         cal_r[$past(cal_idx)] == $past(cal_r[cal_idx]);
   endproperty
   a_lock_wr: assert property (p_lock_wr)
      else $error("locked register changed by bus");

   property p_word;
      ld_we |=> cal_r[$past(ld_idx)] == {$past(nvm_rdata), $past(lo_r)};
   endproperty
   a_word: assert property (p_word)
      else $error("word not assembled high then low");
endmodule // crl_loader

// ---- rtl/crl_pkg.sv ----
// shared constants and types of the calibration register loader
package crl_pkg;
   // clock and refresh timing
   localparam int CLK_MHZ = 100;
   localparam int REFRESH_US = 1000;
   localparam int REFRESH_CYC = REFRESH_US * CLK_MHZ;
   // nonvolatile array organisation
   localparam int NVM_PAGES = 12;
   localparam int PAGE_BYTES = 64;
   localparam int NVM_BYTES = NVM_PAGES * PAGE_BYTES;
   localparam logic [9:0] NVM_TOP = 10'h300;
   localparam logic [7:0] ERASED = 8'hFF;
   // fixed word locations (low byte even, high byte odd) and lock byte location
   localparam logic [9:0] CFG_ADDR = 10'h160;
   localparam logic [9:0] OTC_ADDR = 10'h164;
   localparam logic [9:0] STC_ADDR = 10'h168;
   localparam logic [9:0] LOCK_ADDR = 10'h16A;
   // lookup table bases, byte address = base + 2 * pointer
   localparam logic [9:0] OFS_BASE = 10'h000;
   localparam logic [9:0] SPAN_LO_BASE = 10'h200;
   localparam logic [9:0] SPAN_HI_BASE = 10'h0A0;
   localparam logic [7:0] SPAN_SPLIT = 8'h80;
   localparam logic [7:0] PTR_MAX = 8'hAF;
   // lock byte values
   localparam logic [7:0] LOCK_OPEN = 8'h00;
   localparam logic [7:0] LOCK_RST = 8'hFF;
   // calibration registers
   localparam int NREGS = 5;
   localparam int CFG_INTRES_BIT = 0;
   localparam logic [15:0] CAL_RST = 16'h0000;
   localparam logic [3:0] LAST_STEP = 4'hA;
   // register byte offsets on the bus
   localparam logic [7:0] A_STATUS = 8'h00;
   localparam logic [7:0] A_NADDR = 8'h04;
   localparam logic [7:0] A_NDATA = 8'h08;
   localparam logic [7:0] A_ERASE = 8'h0C;
   localparam logic [7:0] A_CAL0 = 8'h10;
   localparam logic [7:0] A_CALEND = 8'h24;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ADDR = 2'b01,
      ST_DATA = 2'b10
   } crl_st_e;

   typedef struct packed {
      logic [15:0] span_trim;
      logic [15:0] offset_trim;
      logic [15:0] span_tc_trim;
      logic [15:0] offset_tc_trim;
      logic [15:0] config_word;
   } crl_trim_s;
endpackage

// ---- rtl/crl_nvm.sv ----
// byte-wide nonvolatile array with page erase
`timescale 1ns/1ps
module crl_nvm (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [9:0] addr_i,
   input wire logic we_i,
   input wire logic [7:0] wdata_i,
   input wire logic erase_i,
   input wire logic [3:0] page_i,
   output logic [7:0] rdata_o
);
   logic [7:0] mem [crl_pkg::NVM_BYTES];
   wire logic in_range = addr_i < crl_pkg::NVM_TOP;
   wire logic page_ok = 32'(page_i) < crl_pkg::NVM_PAGES;

   // factory state is all bytes erased
   initial begin
      for (int i = 0; i < crl_pkg::NVM_BYTES; i++) begin
         mem[i] = crl_pkg::ERASED;
      end
   end

   always_ff @(posedge clk_i) begin
      if (we_i && in_range) begin
         mem[addr_i] <= wdata_i;
      end
      if (erase_i && page_ok) begin
         for (int i = 0; i < crl_pkg::PAGE_BYTES; i++) begin
            mem[{page_i, 6'(i)}] <= crl_pkg::ERASED;
         end
      end
      rdata_o <= in_range ? mem[addr_i] : crl_pkg::ERASED;
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   property p_erase_keep;
      (erase_i && page_i == 4'h1) |=> mem[0] == $past(mem[0]);
   endproperty
   a_erase_keep: assert property (p_erase_keep)
      else $error("page erase disturbed another page");

   property p_erase_fill;
      (erase_i && page_i == 4'h0) |=> mem[63] == 8'hFF;
   endproperty
   a_erase_fill: assert property (p_erase_fill)
      else $error("page erase missed last byte of page");
endmodule // crl_nvm

// ---- rtl/crl_tick.sv ----
// refresh timer, input synchronisers and temperature pointer clamp
`timescale 1ns/1ps
module crl_tick #(
   parameter int unsigned REFRESH_CYC = crl_pkg::REFRESH_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] temp_code_i,
   input wire logic unlock_i,
   output logic tick_o,
   output logic [7:0] ptr_o,
   output logic unlock_o
);
   localparam int CW = $clog2(REFRESH_CYC);
   localparam logic [CW-1:0] CNT_END = CW'(REFRESH_CYC - 1);
   logic [7:0] temp_m_r;
   logic [7:0] temp_s_r;
   logic unl_m_r;
   logic [CW-1:0] cnt_r;
   wire logic cnt_end = cnt_r == CNT_END;
   wire logic [7:0] clamped;

   assign clamped = (temp_s_r > crl_pkg::PTR_MAX) ? crl_pkg::PTR_MAX
                                                  : temp_s_r;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         temp_m_r <= 8'h00;
         temp_s_r <= 8'h00;
         unl_m_r <= 1'b0;
         unlock_o <= 1'b0;
         cnt_r <= '0;
         tick_o <= 1'b0;
         ptr_o <= 8'h00;
      end else begin
         temp_m_r <= temp_code_i;
         temp_s_r <= temp_m_r;
         unl_m_r <= unlock_i;
         unlock_o <= unl_m_r;
         cnt_r <= cnt_end ? '0 : cnt_r + 1'b1;
         tick_o <= cnt_end;
         if (cnt_end) begin
            ptr_o <= clamped;
         end
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   property p_clamp;
      ptr_o <= 8'hAF;
   endproperty
   a_clamp: assert property (p_clamp)
      else $error("temperature pointer above last entry");

   property p_tick_gap;
      tick_o |=> !tick_o [*8];
   endproperty
   a_tick_gap: assert property (p_tick_gap)
      else $error("refresh ticks too close");
endmodule // crl_tick

// ---- tb/crl_nvm_model.sv ----
// reference model of the byte-wide nonvolatile array
`timescale 1ns/1ps
module crl_nvm_model;
   logic [7:0] mem [crl_pkg::NVM_BYTES];
   initial begin
      for (int i = 0; i < crl_pkg::NVM_BYTES; i++) begin
         mem[i] = crl_pkg::ERASED;
      end
   end
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      mem[a] = d;
   endtask
   task automatic erase(input logic [3:0] pg);
      for (int i = 0; i < crl_pkg::PAGE_BYTES; i++) begin
         mem[pg * crl_pkg::PAGE_BYTES + i] = crl_pkg::ERASED;
      end
   endtask
   function automatic logic [15:0] word(input logic [9:0] a);
      return {mem[a + 10'h001], mem[a]};
   endfunction
endmodule // crl_nvm_model

// ---- tb/crl_loader_bench.sv ----
// self-checking bench of the calibration register loader
`timescale 1ns/1ps
module crl_loader_bench;
   localparam int unsigned RCYC = 64;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0000_0000;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic [7:0] temp_code_i = 8'h00;
   logic lock_override_i = 1'b0;
   crl_pkg::crl_trim_s trims_o;
   logic int_res_sel_o;
   logic cal_mode_o;
   int err_count = 0;
   int n_checks = 0;
   logic [31:0] seed = 32'hA5F50C01;
   logic [31:0] rd;
   crl_nvm_model MDL ();
   crl_loader #(.REFRESH_CYC(RCYC)) DUT (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .temp_code_i(temp_code_i),
      .lock_override_i(lock_override_i), .trims_o(trims_o),
      .int_res_sel_o(int_res_sel_o), .cal_mode_o(cal_mode_o)
   );
   always #5 clk_i = ~clk_i;
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   // span table split between two ranges
   function automatic logic [9:0] span_a(input logic [7:0] p);
      if (p < 8'h80) begin
         return 10'h200 + {1'b0, p, 1'b0};
      end
      return 10'h1A0 + {1'b0, p - 8'h80, 1'b0};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic wb(input logic we, input logic [7:0] a,
                     input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= 4'hF;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 100);
      if (n >= 100) begin
         err_count++;
      end
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic nv_wr(input logic [9:0] a, input logic [7:0] d);
      wb(1'b1, crl_pkg::A_NADDR, {22'h0, a});
      wb(1'b1, crl_pkg::A_NDATA, {24'h0, d});
      MDL.wr(a, d);
   endtask
   task automatic nv_word(input logic [9:0] a, input logic [15:0] w);
      nv_wr(a, w[7:0]);
      nv_wr(a + 10'h001, w[15:8]);
   endtask
   task automatic set_ovr(input logic v, input int cyc);
      @(posedge clk_i);
      lock_override_i <= v;
      repeat (cyc) @(posedge clk_i);
      @(negedge clk_i);
   endtask
   task automatic chk_locked(input logic [7:0] t);
      logic [7:0] p;
      logic [15:0] w;
      p = (t > crl_pkg::PTR_MAX) ? crl_pkg::PTR_MAX : t;
      w = MDL.word(crl_pkg::CFG_ADDR);
      chk(trims_o.config_word, w);
      chk(int_res_sel_o, w[0]);
      chk(trims_o.offset_tc_trim, MDL.word(crl_pkg::OTC_ADDR));
      chk(trims_o.span_tc_trim, MDL.word(crl_pkg::STC_ADDR));
      chk(trims_o.offset_trim, MDL.word({1'b0, p, 1'b0}));
      chk(trims_o.span_trim, MDL.word(span_a(p)));
   endtask
   initial begin
      #200000;
      err_count++;
      print_verdict();
   end
   initial begin
      logic [15:0] ex [5];
      logic [7:0] temps [5];
      logic [9:0] rb [4];
      temps = '{8'h10, 8'h7F, 8'h80, 8'hAF, 8'hF3};
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (40) @(posedge clk_i);
      @(negedge clk_i);
      chk(cal_mode_o, 1'b0);
      chk_locked(8'h00);
      wb(1'b1, crl_pkg::A_CAL0, 32'h0000_1234);
      wb(1'b0, crl_pkg::A_CAL0, 32'h0);
      chk(rd, 32'h0000_FFFF);
      wb(1'b0, 8'h40, 32'h0);
      chk(rd, 32'h0);
      set_ovr(1'b1, 4);
      chk(cal_mode_o, 1'b1);
      for (int i = 0; i < 5; i++) begin
         seed = lfsr(seed);
         ex[i] = seed[15:0];
         wb(1'b1, crl_pkg::A_CAL0 + 8'(4 * i), seed);
         wb(1'b0, crl_pkg::A_CAL0 + 8'(4 * i), 32'h0);
         chk(rd, {16'h0, ex[i]});
      end
      repeat (2 * RCYC + 30) @(posedge clk_i);
      @(negedge clk_i);
      for (int i = 0; i < 5; i++) begin
         chk(trims_o[16 * i +: 16], ex[i]);
      end
      chk(int_res_sel_o, ex[0][0]);
      seed = lfsr(seed);
      nv_word(crl_pkg::CFG_ADDR, {seed[15:1], 1'b0});
      nv_word(crl_pkg::OTC_ADDR, seed[31:16]);
      seed = lfsr(seed);
      nv_word(crl_pkg::STC_ADDR, seed[15:0]);
      for (int k = 0; k < 5; k++) begin
         seed = lfsr(seed);
         nv_word({1'b0, (temps[k] > 8'hAF) ? 8'hAF : temps[k], 1'b0},
                 seed[15:0]);
         nv_word(span_a((temps[k] > 8'hAF) ? 8'hAF : temps[k]),
                 seed[31:16]);
         temp_code_i <= temps[k];
         set_ovr(1'b0, 2 * RCYC + 40);
         chk(cal_mode_o, 1'b0);
         chk_locked(temps[k]);
         set_ovr(1'b1, 4);
      end
      wb(1'b1, crl_pkg::A_ERASE, 32'h0000_0007);
      MDL.erase(4'h7);
      rb = '{10'h1FE, 10'h1FF, 10'h1A0, 10'h220};
      for (int i = 0; i < 4; i++) begin
         wb(1'b1, crl_pkg::A_NADDR, {22'h0, rb[i]});
         wb(1'b0, crl_pkg::A_NDATA, 32'h0);
         chk(rd, {24'h0, MDL.mem[rb[i]]});
      end
      nv_wr(crl_pkg::LOCK_ADDR, crl_pkg::LOCK_OPEN);
      set_ovr(1'b0, 2);
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (40) @(posedge clk_i);
      @(negedge clk_i);
      chk(cal_mode_o, 1'b1);
      chk(trims_o, 80'h0);
      print_verdict();
   end
endmodule // crl_loader_bench
